/* rtl/tc_pkg.sv */
// package: register map, field layout, encodings and timing constants of the timer/counter unit
package tc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_TASK_START   = 12'h000;
  localparam logic [11:0] OFS_TASK_STOP    = 12'h004;
  localparam logic [11:0] OFS_TASK_COUNT   = 12'h008;
  localparam logic [11:0] OFS_TASK_CLEAR   = 12'h00C;
  localparam logic [11:0] OFS_TASK_CAPTURE = 12'h040;
  localparam logic [11:0] OFS_EVT_COMPARE  = 12'h140;
  localparam logic [11:0] OFS_SHORTS       = 12'h200;
  localparam logic [11:0] OFS_INTENSET     = 12'h304;
  localparam logic [11:0] OFS_INTENCLR     = 12'h308;
  localparam logic [11:0] OFS_MODE         = 12'h504;
  localparam logic [11:0] OFS_WIDTH_SEL    = 12'h508;
  localparam logic [11:0] OFS_PRESCALER    = 12'h510;
  localparam logic [11:0] OFS_CC           = 12'h540;
  localparam logic [11:0] OFS_STRIDE       = 12'h004;
  localparam logic [11:0] OFS_STATUS       = 12'h600;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int          MAX_CC          = 6;
  localparam int          SHORT_STOP_POS  = 6;
  localparam int          CNT_W           = 32;
  localparam int          PRE_W           = 4;
  localparam logic [3:0]  PRESCALER_RST   = 4'h4;
  localparam logic [1:0]  MODE_RST        = 2'h0;
  localparam logic [1:0]  WIDTH_SEL_RST   = 2'h0;

  typedef enum logic [1:0] {
    TC_MODE_TIMER   = 2'h0,
    TC_MODE_COUNTER = 2'h1,
    TC_MODE_LOWPWR  = 2'h2
  } tc_mode_t;

  typedef enum logic [1:0] {
    TC_W16 = 2'h0,
    TC_W8  = 2'h1,
    TC_W24 = 2'h2,
    TC_W32 = 2'h3
  } tc_width_t;

  localparam logic [31:0] MASK_W8  = 32'h0000_00FF;
  localparam logic [31:0] MASK_W16 = 32'h0000_FFFF;
  localparam logic [31:0] MASK_W24 = 32'h00FF_FFFF;
  localparam logic [31:0] MASK_W32 = 32'hFFFF_FFFF;

  // ----------------------------------------------------------------
  // timing: base tick rates, and step and divider constants derived from them and the system clock rate
  // ----------------------------------------------------------------
  localparam int CLK_HZ        = 25_000_000;
  localparam int BASE_HZ       = 16_000_000;
  localparam int SLOW_HZ       = 1_000_000;
  localparam int PHASE_MOD     = CLK_HZ / SLOW_HZ;
  localparam int FAST_STEP     = BASE_HZ / SLOW_HZ;
  localparam int SLOW_DIV      = CLK_HZ / SLOW_HZ;
  localparam logic [3:0] SLOW_EXP_MIN = 4'h4;

  // ----------------------------------------------------------------
  // task strobes from the event interconnect
  // ----------------------------------------------------------------
  typedef struct packed {
    logic start;
    logic stop;
    logic count;
    logic clear;
  } tc_task_t;

endpackage : tc_pkg

/* rtl/tc_tick_gen.sv */
// tick generator: 16 MHz and 1 MHz base pulses and power-of-two prescaler
module tc_tick_gen (
  input  wire logic       i_clk,
  input  wire logic       i_rst_b,
  input  wire logic [3:0] i_prescale,
  input  wire logic       i_run,
  output logic            o_tick,
  output logic            o_slow_sel
);

  logic [4:0]  fast_acc_r;
  logic [4:0]  slow_acc_r;
  logic        fast_pulse;
  logic        slow_pulse;
  logic        src_pulse;
  logic [3:0]  shift;
  logic [15:0] div_r;
  logic [15:0] div_mask;

  // ----------------------------------------------------------------
  // fractional accumulator: 16 pulses every 25 clocks
  // ----------------------------------------------------------------
  assign fast_pulse = ({1'b0, fast_acc_r} + 6'(tc_pkg::FAST_STEP)) >= 6'(tc_pkg::PHASE_MOD);

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      fast_acc_r <= 5'h00;
    end else if (fast_pulse) begin
      fast_acc_r <= 5'(fast_acc_r + 5'(tc_pkg::FAST_STEP) - 5'(tc_pkg::PHASE_MOD));
    end else begin
      fast_acc_r <= 5'(fast_acc_r + 5'(tc_pkg::FAST_STEP));
    end
  end

  assign slow_pulse = (slow_acc_r == 5'(tc_pkg::SLOW_DIV - 1));

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      slow_acc_r <= 5'h00;
    end else begin
      slow_acc_r <= slow_pulse ? 5'h00 : 5'(slow_acc_r + 5'h01);
    end
  end

  // ----------------------------------------------------------------
  // slow source at 1 MHz and below; same rate, fewer toggles
  // ----------------------------------------------------------------
  assign o_slow_sel = (i_prescale >= tc_pkg::SLOW_EXP_MIN);
  assign src_pulse  = o_slow_sel ? slow_pulse : fast_pulse;
  assign shift      = o_slow_sel ? 4'(i_prescale - tc_pkg::SLOW_EXP_MIN) : i_prescale;
  assign div_mask   = 16'((17'h1 << shift) - 17'h1);

  // divider restarts at stop so the first tick after a start is a full period
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || !i_run) begin
      div_r <= 16'h0000;
    end else if (src_pulse) begin
      div_r <= ((div_r & div_mask) == div_mask) ? 16'h0000 : 16'(div_r + 16'h0001);
    end
  end

  assign o_tick = i_run && src_pulse && ((div_r & div_mask) == div_mask);

endmodule // tc_tick_gen

/* rtl/tc_timer_unit.sv */
// top: timer/counter unit with capture/compare slots behind an AHB-Lite slave
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
module tc_timer_unit #(
  parameter int NUM_CC = 4
) (
  input  wire logic              I_REF_CLK,
  input  wire logic              I_RST_B,
  input  wire logic              I_HSEL,
  input  wire logic [31:0]       I_HADDR,
  input  wire logic [1:0]        I_HTRANS,
  input  wire logic              I_HWRITE,
  input  wire logic [2:0]        I_HSIZE,
  input  wire logic [31:0]       I_HWDATA,
  input  wire logic              I_HREADY,
  input  wire tc_pkg::tc_task_t  I_TASKS,
  input  wire logic [5:0]        I_TASK_CAPTURE,
  output logic                   O_HREADYOUT,
  output logic                   O_HRESP,
  output logic [31:0]            O_HRDATA,
  output logic [5:0]             O_EVT_COMPARE,
  output logic                   O_IRQ,
  output logic                   O_RUNNING,
  output logic                   O_SLOW_CLK_SEL
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                 running_r;
  logic [31:0]          counter_r;
  logic [31:0]          counter_nxt;
  logic [31:0]          cc_r [tc_pkg::MAX_CC];
  logic [5:0]           evt_flag_r;
  logic [5:0]           evt_pulse_r;
  logic [5:0]           match;
  logic [11:0]          shorts_r;
  logic [5:0]           inten_r;
  logic [1:0]           mode_r;
  logic [1:0]           width_r;
  logic [3:0]           prescale_r;
  logic [31:0]          width_mask;
  logic                 tick;
  logic                 slow_sel;

  // bus pipeline
  logic                 wr_pend_r;
  logic [11:0]          wr_addr_r;
  logic                 addr_ok;
  logic [31:0]          rdata;

  // task decode
  logic                 bus_start;
  logic                 bus_stop;
  logic                 bus_count;
  logic                 bus_clear;
  logic [5:0]           bus_capture;
  logic                 start_req;
  logic                 stop_req;
  logic                 count_req;
  logic                 clear_req;
  logic                 inc;
  logic                 counter_mode;
  logic [5:0]           slot_ok;

  // ----------------------------------------------------------------
  // tick source
  // ----------------------------------------------------------------
  tc_tick_gen u_tick (
    .i_clk      (I_REF_CLK),
    .i_rst_b    (I_RST_B),
    .i_prescale (prescale_r),
    .i_run      (running_r),
    .o_tick     (tick),
    .o_slow_sel (slow_sel)
  );

  // ----------------------------------------------------------------
  // AHB-Lite slave: zero wait state, always OKAY
  // ----------------------------------------------------------------
  assign addr_ok = I_HSEL && I_HTRANS[1] && I_HREADY;

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 12'h000;
    end else begin
      wr_pend_r <= addr_ok && I_HWRITE;
      wr_addr_r <= I_HADDR[11:0];
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
      O_HRDATA    <= 32'h0000_0000;
    end else begin
      O_HREADYOUT <= 1'b1;
      O_HRESP     <= 1'b0;
      if (addr_ok && !I_HWRITE) begin
        O_HRDATA <= rdata;
      end
    end
  end

  // unmapped addresses and write-only task registers read as zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (I_HADDR[11:0])
      tc_pkg::OFS_SHORTS:    rdata = {20'h00000, shorts_r};
      tc_pkg::OFS_INTENSET:  rdata = {26'h0000000, inten_r};
      tc_pkg::OFS_INTENCLR:  rdata = {26'h0000000, inten_r};
      tc_pkg::OFS_MODE:      rdata = {30'h00000000, mode_r};
      tc_pkg::OFS_WIDTH_SEL: rdata = {30'h00000000, width_r};
      tc_pkg::OFS_PRESCALER: rdata = {28'h0000000, prescale_r};
      tc_pkg::OFS_STATUS:    rdata = {30'h00000000, slow_sel, running_r};
      default:               rdata = 32'h0000_0000;
    endcase
    for (int i = 0; i < NUM_CC; i++) begin
      if (I_HADDR[11:0] == 12'(tc_pkg::OFS_EVT_COMPARE + 12'(i) * tc_pkg::OFS_STRIDE)) begin
        rdata = {31'h00000000, evt_flag_r[i]};
      end
      if (I_HADDR[11:0] == 12'(tc_pkg::OFS_CC + 12'(i) * tc_pkg::OFS_STRIDE)) begin
        rdata = cc_r[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      mode_r     <= tc_pkg::MODE_RST;
      width_r    <= tc_pkg::WIDTH_SEL_RST;
      prescale_r <= tc_pkg::PRESCALER_RST;
      shorts_r   <= 12'h000;
    end else if (wr_pend_r) begin
      // changing prescaler or width while running is tolerated but undefined
      unique case (wr_addr_r)
        tc_pkg::OFS_MODE:      mode_r     <= I_HWDATA[1:0];
        tc_pkg::OFS_WIDTH_SEL: width_r    <= I_HWDATA[1:0];
        tc_pkg::OFS_PRESCALER: prescale_r <= I_HWDATA[3:0];
        tc_pkg::OFS_SHORTS:    shorts_r   <= I_HWDATA[11:0];
        default:               ;
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      inten_r <= 6'h00;
    end else if (wr_pend_r && wr_addr_r == tc_pkg::OFS_INTENSET) begin
      inten_r <= inten_r | I_HWDATA[5:0];
    end else if (wr_pend_r && wr_addr_r == tc_pkg::OFS_INTENCLR) begin
      inten_r <= inten_r & ~I_HWDATA[5:0];
    end
  end

  // ----------------------------------------------------------------
  // task gathering: bus writes, interconnect strobes, shortcuts
  // ----------------------------------------------------------------
  assign bus_start = wr_pend_r && wr_addr_r == tc_pkg::OFS_TASK_START && I_HWDATA[0];
  assign bus_stop  = wr_pend_r && wr_addr_r == tc_pkg::OFS_TASK_STOP  && I_HWDATA[0];
  assign bus_count = wr_pend_r && wr_addr_r == tc_pkg::OFS_TASK_COUNT && I_HWDATA[0];
  assign bus_clear = wr_pend_r && wr_addr_r == tc_pkg::OFS_TASK_CLEAR && I_HWDATA[0];

  always_comb begin
    bus_capture = 6'h00;
    for (int i = 0; i < NUM_CC; i++) begin
      bus_capture[i] = wr_pend_r && I_HWDATA[0]
                       && wr_addr_r == 12'(tc_pkg::OFS_TASK_CAPTURE + 12'(i) * tc_pkg::OFS_STRIDE);
    end
  end

  assign slot_ok   = 6'((7'h1 << NUM_CC) - 7'h1);
  assign start_req = I_TASKS.start || bus_start;
  assign stop_req  = I_TASKS.stop || bus_stop
                     || |(evt_pulse_r & shorts_r[tc_pkg::SHORT_STOP_POS +: tc_pkg::MAX_CC] & slot_ok);
  assign count_req = I_TASKS.count || bus_count;
  assign clear_req = I_TASKS.clear || bus_clear
                     || |(evt_pulse_r & shorts_r[0 +: tc_pkg::MAX_CC] & slot_ok);

  // ----------------------------------------------------------------
  // run control
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      running_r <= 1'b0;
    end else if (stop_req) begin
      running_r <= 1'b0;
    end else if (start_req) begin
      running_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_comb begin
    unique case (tc_pkg::tc_width_t'(width_r))
      tc_pkg::TC_W8:  width_mask = tc_pkg::MASK_W8;
      tc_pkg::TC_W16: width_mask = tc_pkg::MASK_W16;
      tc_pkg::TC_W24: width_mask = tc_pkg::MASK_W24;
      tc_pkg::TC_W32: width_mask = tc_pkg::MASK_W32;
    endcase
  end

  // the unused mode code 3 falls back to timer behaviour
  assign counter_mode = (mode_r == tc_pkg::TC_MODE_COUNTER) || (mode_r == tc_pkg::TC_MODE_LOWPWR);
  assign inc = running_r && (counter_mode ? count_req : tick);

  always_comb begin
    if (clear_req) begin
      counter_nxt = 32'h0000_0000;
    end else if (inc) begin
      counter_nxt = (counter_r + 32'h0000_0001) & width_mask;
    end else begin
      counter_nxt = counter_r;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      counter_r <= 32'h0000_0000;
    end else begin
      counter_r <= counter_nxt;
    end
  end

  // ----------------------------------------------------------------
  // capture/compare slots
  // ----------------------------------------------------------------
  for (genvar g = 0; g < tc_pkg::MAX_CC; g++) begin : g_slot
    if (g < NUM_CC) begin : g_used
      assign match[g] = inc && !clear_req && (((counter_nxt ^ cc_r[g]) & width_mask) == 32'h0000_0000);

      always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
          cc_r[g] <= 32'h0000_0000;
        end else if (I_TASK_CAPTURE[g] || bus_capture[g]) begin
          cc_r[g] <= counter_r;
        end else if (wr_pend_r && wr_addr_r == 12'(tc_pkg::OFS_CC + 12'(g) * tc_pkg::OFS_STRIDE)) begin
          cc_r[g] <= I_HWDATA;
        end
      end

      // a match in the same cycle as a software clear keeps the flag set
      always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_B) begin
          evt_flag_r[g] <= 1'b0;
        end else if (match[g]) begin
          evt_flag_r[g] <= 1'b1;
        end else if (wr_pend_r && wr_addr_r == 12'(tc_pkg::OFS_EVT_COMPARE + 12'(g) * tc_pkg::OFS_STRIDE)) begin
          evt_flag_r[g] <= I_HWDATA[0];
        end
      end
    end else begin : g_absent
      assign match[g]      = 1'b0;
      assign cc_r[g]       = 32'h0000_0000;
      assign evt_flag_r[g] = 1'b0;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      evt_pulse_r <= 6'h00;
    end else begin
      evt_pulse_r <= match;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    if (!I_RST_B) begin
      O_IRQ          <= 1'b0;
      O_RUNNING      <= 1'b0;
      O_SLOW_CLK_SEL <= 1'b0;
    end else begin
      O_IRQ          <= |(evt_flag_r & inten_r);
      O_RUNNING      <= running_r;
      O_SLOW_CLK_SEL <= slow_sel;
    end
  end

  assign O_EVT_COMPARE = evt_pulse_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_stop_wins: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (start_req && stop_req) |=> !running_r)
    else $error("start and stop together left unit running");

  a_start_runs: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (start_req && !stop_req) |=> running_r)
    else $error("start task did not start the unit");

  a_clear_zero: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    clear_req |=> (counter_r == 32'h0000_0000))
    else $error("clear task did not zero the counter");

  a_count_in_timer: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (!counter_mode && count_req && !tick && !clear_req) |=> $stable(counter_r))
    else $error("count task changed counter in timer mode");

  a_count_step: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (counter_mode && running_r && count_req && !clear_req)
      |=> counter_r == ((($past(counter_r) + 32'h0000_0001)) & $past(width_mask)))
    else $error("counter mode did not add exactly one");

  a_tick_step: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (!counter_mode && running_r && !clear_req && !tick) |=> $stable(counter_r))
    else $error("timer moved without a tick");

  // a narrowed width only trims the counter on its next increment, so check after increments
  a_width_limit: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (inc && !clear_req) |=> ((counter_r & ~$past(width_mask)) == 32'h0000_0000))
    else $error("counter exceeds selected width");

  a_hold_stopped: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (!running_r && !clear_req) |=> $stable(counter_r))
    else $error("stopped counter changed");

  a_capture_copy: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    ((I_TASK_CAPTURE[0] || bus_capture[0]) && NUM_CC > 0) |=> (cc_r[0] == $past(counter_r)))
    else $error("capture did not copy counter into slot 0");

  a_match_flag: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    match[0] |=> (evt_flag_r[0] && O_EVT_COMPARE[0]) ##1 !O_EVT_COMPARE[0] || match[0])
    else $error("match did not raise slot 0 event");

  a_short_clear: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (evt_pulse_r[0] && shorts_r[0]) |=> (counter_r == 32'h0000_0000))
    else $error("compare-to-clear shortcut failed");

  a_irq_follow: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_B)
    (|(evt_flag_r & inten_r)) |=> O_IRQ)
    else $error("enabled flag did not raise interrupt");

endmodule // tc_timer_unit

/* testbench/tc_evt_src.sv */
// partner model: task/event interconnect that issues task pulses and watches match events
module tc_evt_src (
  input  wire logic        i_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_req,
  input  wire logic [3:0]  i_tasks,
  input  wire logic [5:0]  i_cap,
  input  wire logic [15:0] i_reps,
  input  wire logic [3:0]  i_gap,
  input  wire logic [5:0]  i_evt,
  output tc_pkg::tc_task_t o_tasks,
  output logic [5:0]       o_cap,
  output logic             o_busy,
  output logic [5:0]       o_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] left_r;
  logic [3:0]  wait_r;
  logic [3:0]  tk_r;
  logic [5:0]  cp_r;
  // ----------------------------------------------------------------
  // pulse train: gap 0 gives back-to-back triggers, larger gaps a slow source
  // ----------------------------------------------------------------
  assign o_busy = (left_r != 16'h0) || (o_tasks != 4'h0);
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      left_r  <= 16'h0;
      wait_r  <= 4'h0;
      tk_r    <= 4'h0;
      cp_r    <= 6'h0;
      o_tasks <= '0;
      o_cap   <= 6'h0;
    end else if (i_req) begin
      left_r <= i_reps;
      wait_r <= 4'h0;
      tk_r   <= i_tasks;
      cp_r   <= i_cap;
    end else if (left_r != 16'h0 && wait_r == 4'h0) begin
      o_tasks <= tc_pkg::tc_task_t'(tk_r);
      o_cap   <= cp_r;
      left_r  <= left_r - 16'h1;
      wait_r  <= i_gap;
    end else begin
      o_tasks <= '0;
      o_cap   <= 6'h0;
      if (wait_r != 4'h0) wait_r <= wait_r - 4'h1;
    end
  end
  // sticky so the bench need not catch the one-cycle pulse itself
  always_ff @(posedge i_clk) begin
    if (!i_rst_b || i_req) o_seen <= 6'h0;
    else o_seen <= o_seen | i_evt;
  end
endmodule // tc_evt_src

/* testbench/tb.sv */
// testbench: bus and task stimulus with self-checks for the timer/counter unit
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [1:0] mode; logic [1:0] w; logic [15:0] n; logic [31:0] ex;} tc_row_t;
  localparam int LIMIT = 20000;
  logic clk = 1'b0, rst_b = 1'b0, hsel = 1'b0, hwrite = 1'b0, req = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, v, lo, hi;
  logic [1:0]  htrans = 2'h0;
  logic [3:0]  rq_t = 4'h0, gap = 4'h0;
  logic [5:0]  rq_c = 6'h0, evt, cap, seen;
  logic [15:0] reps = 16'h1;
  logic [31:0] hrdata;
  logic        hready, hresp, irq, running, slow, busy;
  tc_pkg::tc_task_t tasks;
  int fail_count = 0, total_checks = 0, cyc = 0;
  tc_row_t rows [5] = '{'{2'h1, 2'h1, 16'h0101, 32'h1}, '{2'h1, 2'h1, 16'h00FF, 32'hFF},
    '{2'h1, 2'h0, 16'h012C, 32'h12C}, '{2'h2, 2'h2, 16'h5, 32'h5}, '{2'h1, 2'h3, 16'h7, 32'h7}};
  always #20 clk = ~clk;
  tc_timer_unit u_tc_timer_unit (.I_REF_CLK(clk), .I_RST_B(rst_b), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
    .I_TASKS(tasks), .I_TASK_CAPTURE(cap), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_HRDATA(hrdata),
    .O_EVT_COMPARE(evt), .O_IRQ(irq), .O_RUNNING(running), .O_SLOW_CLK_SEL(slow));
  tc_evt_src u_tc_evt_src (.i_clk(clk), .i_rst_b(rst_b), .i_req(req), .i_tasks(rq_t), .i_cap(rq_c),
    .i_reps(reps), .i_gap(gap), .i_evt(evt), .o_tasks(tasks), .o_cap(cap), .o_busy(busy), .o_seen(seen));
  // ----------------------------------------------------------------
  // closing and hang guard
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      fail_count++;
      report_and_stop;
    end
  end
  // ----------------------------------------------------------------
  // bus and task helpers
  // ----------------------------------------------------------------
  task bus(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1; haddr <= {20'h0, a}; htrans <= 2'h2; hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0; hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task rd(input logic [11:0] a);
    bus(1'b0, a, 32'h0, v);
  endtask
  task capv(input int n);
    wr(tc_pkg::OFS_TASK_CAPTURE + 12'(4 * n), 32'h1);
    rd(tc_pkg::OFS_CC + 12'(4 * n));
  endtask
  // each high cycle of a strobe counts as one trigger
  task fire(input logic [3:0] t, input logic [5:0] c, input logic [15:0] n, input logic [3:0] g);
    @(posedge clk);
    req <= 1'b1; rq_t <= t; rq_c <= c; reps <= n; gap <= g;
    @(posedge clk);
    req <= 1'b0;
    do @(posedge clk); while (busy === 1'b1);
    // one more edge so the sticky event record has taken the last pulse
    @(posedge clk);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    rd(tc_pkg::OFS_PRESCALER); `CHK("prescaler", 32'h4, v)
    rd(tc_pkg::OFS_MODE); `CHK("mode", 32'h0, v)
    rd(tc_pkg::OFS_WIDTH_SEL); `CHK("width", 32'h0, v)
    rd(12'h700); `CHK("unmapped", 32'h0, v)
    `CHK("hresp", 1'b0, hresp)
    `CHK("slow_sel", 1'b1, slow)
    for (int i = 0; i < 5; i++) begin
      wr(tc_pkg::OFS_TASK_STOP, 32'h1);
      wr(tc_pkg::OFS_MODE, {30'h0, rows[i].mode});
      wr(tc_pkg::OFS_WIDTH_SEL, {30'h0, rows[i].w});
      wr(tc_pkg::OFS_TASK_START, 32'h1);
      fire(4'h1, 6'h0, 16'h1, 4'h0);
      fire(4'h2, 6'h0, rows[i].n, 4'h0);
      fire(4'h0, 6'h2, 16'h1, 4'h0);
      rd(tc_pkg::OFS_CC + 12'h4); `CHK("row_count", rows[i].ex, v)
    end
    wr(tc_pkg::OFS_TASK_STOP, 32'h1);
    fire(4'hC, 6'h0, 16'h1, 4'h0);
    rd(tc_pkg::OFS_STATUS); `CHK("start_stop", 1'b0, v[0])
    wr(tc_pkg::OFS_MODE, 32'h0);
    for (int p = 0; p <= 4; p += 4) begin
      wr(tc_pkg::OFS_PRESCALER, 32'(p));
      fire(4'h1, 6'h0, 16'h1, 4'h0);
      wr(tc_pkg::OFS_TASK_START, 32'h1);
      repeat (250) @(posedge clk);
      capv(0);
      wr(tc_pkg::OFS_TASK_STOP, 32'h1);
      // about 253 clocks from start landing to capture landing
      hi = ((32'd253 * 32'd16) >> p) / 32'd25;
      lo = hi - 32'h2;
      `CHK("tick_count", 1'b1, (v >= lo && v <= hi + 32'h1))
      `CHK("slow_sel", (p >= 4), slow)
    end
    wr(tc_pkg::OFS_PRESCALER, 32'h9);
    fire(4'h1, 6'h0, 16'h1, 4'h0);
    wr(tc_pkg::OFS_TASK_START, 32'h1);
    fire(4'h2, 6'h0, 16'hA, 4'h0);
    capv(0); `CHK("timer_count_task", 32'h0, v)
    wr(tc_pkg::OFS_TASK_STOP, 32'h1);
    wr(tc_pkg::OFS_MODE, 32'h1);
    wr(tc_pkg::OFS_WIDTH_SEL, 32'h0);
    wr(tc_pkg::OFS_CC, 32'h3);
    wr(tc_pkg::OFS_SHORTS, 32'h1);
    wr(tc_pkg::OFS_INTENSET, 32'h1);
    fire(4'h1, 6'h0, 16'h1, 4'h0);
    wr(tc_pkg::OFS_TASK_START, 32'h1);
    fire(4'h2, 6'h0, 16'h3, 4'h3);
    `CHK("match0", 1'b1, seen[0])
    rd(tc_pkg::OFS_EVT_COMPARE); `CHK("flag0", 32'h1, v)
    `CHK("irq_on", 1'b1, irq)
    capv(1); `CHK("short_clear", 32'h0, v)
    wr(tc_pkg::OFS_EVT_COMPARE, 32'h0);
    repeat (2) @(posedge clk);
    `CHK("irq_off", 1'b0, irq)
    wr(tc_pkg::OFS_TASK_STOP, 32'h1);
    wr(tc_pkg::OFS_WIDTH_SEL, 32'h1);
    wr(tc_pkg::OFS_SHORTS, 32'h100);
    wr(tc_pkg::OFS_CC + 12'h8, 32'h105);
    fire(4'h1, 6'h0, 16'h1, 4'h0);
    wr(tc_pkg::OFS_TASK_START, 32'h1);
    fire(4'h2, 6'h0, 16'h5, 4'h0);
    `CHK("match_masked", 1'b1, seen[2])
    repeat (2) @(posedge clk);
    `CHK("short_stop", 1'b0, running)
    fire(4'h2, 6'h0, 16'h2, 4'h0);
    wr(tc_pkg::OFS_TASK_START, 32'h1);
    fire(4'h2, 6'h0, 16'h1, 4'h0);
    capv(1); `CHK("resume", 32'h6, v)
    // reset in mid-run while the unit is counting
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    `CHK("rst_running", 1'b0, running)
    rd(tc_pkg::OFS_WIDTH_SEL); `CHK("rst_width", 32'h0, v)
    report_and_stop;
  end
endmodule // tb
